// ==== shared/dpdc_defs.svh ====
// Opcodes, widths and timing counts for the power-state control link
`ifndef DPDC_DEFS_SVH
`define DPDC_DEFS_SVH
`define DPDC_OP_ENTER      8'hB9
`define DPDC_OP_RELEASE    8'hAB
`define DPDC_OP_W          8
`define DPDC_ID_W          24
`define DPDC_CLK_SINGLE    4'h8
`define DPDC_CLK_QUAD      4'h2
`define DPDC_DUMMY_CLK     4'h3
`define DPDC_REF_NS        10
`define DPDC_T_ENTER_NS    3000
`define DPDC_T_WAKE_NS     10000
`define DPDC_ENTER_CYC     (`DPDC_T_ENTER_NS / `DPDC_REF_NS)
`define DPDC_WAKE_CYC      (`DPDC_T_WAKE_NS / `DPDC_REF_NS)
`define DPDC_SYNC_MARGIN   8
`define DPDC_CNT_W         11
`define DPDC_GAP_CYC       4'hF
`endif

// ==== shared/dpdc_pkg.sv ====
// Types shared by both ends of the power-state control link
package dpdc_pkg;
  typedef enum logic [3:0] {
    DST_STANDBY = 4'h1,
    DST_ENTER   = 4'h2,
    DST_LOWPWR  = 4'h4,
    DST_WAKE    = 4'h8
  } dpdc_dev_state_t;

  typedef enum logic [7:0] {
    HST_IDLE  = 8'h01,
    HST_SETUP = 8'h02,
    HST_OP    = 8'h04,
    HST_DUMMY = 8'h08,
    HST_READ  = 8'h10,
    HST_END   = 8'h20,
    HST_GAP   = 8'h40,
    HST_WAKE  = 8'h80
  } dpdc_host_state_t;
endpackage : dpdc_pkg

// ==== shared/dpdc_link_if.sv ====
// Serial link between the host controller and the flash power-state logic
`timescale 1ns/1ps
interface dpdc_link_if;
  logic       sck;
  logic       ce_n;
  logic [3:0] host_dq_o;
  logic [3:0] host_dq_oe;
  logic [3:0] dev_dq_o;
  logic [3:0] dev_dq_oe;
  logic [3:0] dq;

  // Line level from the enables; an undriven line floats high (pull-up)
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign dq[i] = host_dq_oe[i] ? host_dq_o[i] : (dev_dq_oe[i] ? dev_dq_o[i] : 1'b1);
  end

  modport dev  (input sck, input ce_n, input dq, output dev_dq_o, output dev_dq_oe);
  modport host (output sck, output ce_n, input dq, output host_dq_o, output host_dq_oe);
endinterface : dpdc_link_if

// ==== design/dpdc_device.sv ====
// Flash-side power-state control: opcode capture, low-power state, ID readout
//
// Contract
// - Opcode B9H under low enable enters low power.
// - Enter opcode ignored during program or erase.
// - In low power, only release opcode honoured.
// - Enter acts on enable rising, not opcode.
// - Low power reached within 3 us.
// - Opcode ABH then enable high returns standby.
// - Standby and ready within 10 us.
// - Host gives three dummy clocks before ID.
// - ID bits driven on falling clock edges.
// - ID repeats until enable high, then standby.
`timescale 1ns/1ps
`include "dpdc_defs.svh"
module dpdc_device (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_quad_mode,
  input  wire logic                   i_wr_busy,
  dpdc_link_if.dev                    link,
  output logic                        o_low_power,
  output logic                        o_ready,
  output logic                        o_cmd_valid,
  output logic [`DPDC_OP_W-1:0]       o_cmd_code
);
  localparam logic [`DPDC_ID_W-1:0] DEV_ID = 24'h5A_C3_17; // Arbitrary identifier value
  localparam logic [`DPDC_CNT_W-1:0] ENTER_CYC =
    `DPDC_CNT_W'(`DPDC_ENTER_CYC - `DPDC_SYNC_MARGIN);
  localparam logic [`DPDC_CNT_W-1:0] WAKE_CYC =
    `DPDC_CNT_W'(`DPDC_WAKE_CYC - `DPDC_SYNC_MARGIN);

  // Clocks needed for one opcode in the current line mode
  function automatic logic [3:0] op_clocks(input logic quad);
    op_clocks = quad ? `DPDC_CLK_QUAD : `DPDC_CLK_SINGLE;
  endfunction : op_clocks

  // ---------------- Link clock domain ----------------
  // Frame logic is held clear while enable is high, since the clock
  // stops between frames and no edge would clear it otherwise.
  logic                 frame_rst_n;
  logic                 quad_s1_r;
  logic                 quad_s2_r;
  logic [3:0]           cnt_r;
  logic [3:0]           cnt_nxt;
  logic [`DPDC_OP_W-1:0] sh_r;
  logic [`DPDC_OP_W-1:0] sh_nxt;
  logic                 rel_r;
  logic                 rel_nxt;
  logic [`DPDC_OP_W-1:0] opcode_r;
  logic [`DPDC_OP_W-1:0] opcode_nxt;
  logic                 tog_r;
  logic                 tog_nxt;
  logic                 op_done;

  assign frame_rst_n = i_rst_n & ~link.ce_n;

  // Shift in opcode bits on rising clock edges
  always_comb begin
    cnt_nxt    = (cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1;
    sh_nxt     = sh_r;
    rel_nxt    = rel_r;
    opcode_nxt = opcode_r;
    tog_nxt    = tog_r;
    op_done    = 1'b0;
    if (cnt_r < op_clocks(quad_s2_r)) begin
      if (quad_s2_r) begin
        sh_nxt = {sh_r[`DPDC_OP_W-5:0], link.dq};
      end else begin
        sh_nxt = {sh_r[`DPDC_OP_W-2:0], link.dq[0]};
      end
      op_done = (cnt_nxt == op_clocks(quad_s2_r));
    end
    if (op_done) begin
      opcode_nxt = sh_nxt;
      tog_nxt    = ~tog_r;
      rel_nxt    = (sh_nxt == `DPDC_OP_RELEASE);
    end
  end

  always_ff @(posedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
      rel_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      rel_r <= rel_nxt;
    end
  end

  // Opcode hold and handoff toggle survive the frame end for the other side
  always_ff @(posedge link.sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opcode_r  <= 8'h00;
      tog_r     <= 1'b0;
    end else begin
      opcode_r  <= opcode_nxt;
      tog_r     <= tog_nxt;
    end
  end

  // Identifier drive on falling edges after the dummy clocks
  logic [`DPDC_ID_W-1:0] id_r;
  logic [`DPDC_ID_W-1:0] id_nxt;
  logic                  drv_r;
  logic                  drv_nxt;
  logic [3:0]            dq_o_r;
  logic [3:0]            dq_o_nxt;
  logic [3:0]            dq_oe_r;
  logic [3:0]            dq_oe_nxt;

  always_comb begin
    id_nxt    = id_r;
    drv_nxt   = drv_r;
    dq_o_nxt  = dq_o_r;
    dq_oe_nxt = dq_oe_r;
    if (rel_r && cnt_r >= op_clocks(quad_s2_r) + `DPDC_DUMMY_CLK) begin
      if (!drv_r) begin
        id_nxt  = DEV_ID;
        drv_nxt = 1'b1;
      end else if (quad_s2_r) begin
        id_nxt = {id_r[`DPDC_ID_W-5:0], id_r[`DPDC_ID_W-1 -: 4]};
      end else begin
        id_nxt = {id_r[`DPDC_ID_W-2:0], id_r[`DPDC_ID_W-1]};
      end
      // Single-line answers go out on the second line, quad on all four
      if (quad_s2_r) begin
        dq_o_nxt  = id_nxt[`DPDC_ID_W-1 -: 4];
        dq_oe_nxt = 4'hF;
      end else begin
        dq_o_nxt  = {2'b00, id_nxt[`DPDC_ID_W-1], 1'b0};
        dq_oe_nxt = 4'h2;
      end
    end
  end

  // Enable high releases the lines at once, ending the stream
  always_ff @(negedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      id_r    <= 24'h000000;
      drv_r   <= 1'b0;
      dq_o_r  <= 4'h0;
      dq_oe_r <= 4'h0;
    end else begin
      id_r    <= id_nxt;
      drv_r   <= drv_nxt;
      dq_o_r  <= dq_o_nxt;
      dq_oe_r <= dq_oe_nxt;
    end
  end

  assign link.dev_dq_o  = dq_o_r;
  assign link.dev_dq_oe = dq_oe_r;

  // ---------------- Reference clock domain ----------------
  logic                     ce_s1_r;
  logic                     ce_s2_r;
  logic                     ce_s3_r;
  logic                     tg_s1_r;
  logic                     tg_s2_r;
  logic                     tg_s3_r;
  logic [`DPDC_OP_W-1:0]    op_lat_r;
  logic [`DPDC_OP_W-1:0]    op_lat_nxt;
  logic                     have_r;
  logic                     have_nxt;
  dpdc_pkg::dpdc_dev_state_t st_r;
  dpdc_pkg::dpdc_dev_state_t st_nxt;
  logic [`DPDC_CNT_W-1:0]   tmr_r;
  logic [`DPDC_CNT_W-1:0]   tmr_nxt;
  logic                     vld_nxt;
  logic [`DPDC_OP_W-1:0]    code_nxt;
  logic                     ce_rise;
  logic                     tg_chg;

  assign ce_rise = ce_s2_r & ~ce_s3_r;
  assign tg_chg  = tg_s2_r ^ tg_s3_r;

  // Opcode words are stable long before the toggle lands, so a plain capture is safe
  always_comb begin
    op_lat_nxt = tg_chg ? opcode_r : op_lat_r;
    have_nxt   = tg_chg | (have_r & ~ce_rise);
    st_nxt     = st_r;
    tmr_nxt    = (tmr_r == 11'h000) ? tmr_r : tmr_r - 11'h001;
    vld_nxt    = 1'b0;
    code_nxt   = o_cmd_code;
    unique case (st_r)
      dpdc_pkg::DST_STANDBY: begin
        if (ce_rise && have_r) begin
          if (op_lat_r == `DPDC_OP_ENTER) begin
            if (!i_wr_busy) begin
              st_nxt  = dpdc_pkg::DST_ENTER;
              tmr_nxt = ENTER_CYC;
            end
          end else begin
            vld_nxt  = 1'b1;
            code_nxt = op_lat_r;
          end
        end
      end
      dpdc_pkg::DST_ENTER: begin
        if (ce_rise && have_r && op_lat_r == `DPDC_OP_RELEASE) begin
          st_nxt  = dpdc_pkg::DST_WAKE;
          tmr_nxt = WAKE_CYC;
        end else if (tmr_r == 11'h000) begin
          st_nxt = dpdc_pkg::DST_LOWPWR;
        end
      end
      dpdc_pkg::DST_LOWPWR: begin
        // Any other opcode is dropped here
        if (ce_rise && have_r && op_lat_r == `DPDC_OP_RELEASE) begin
          st_nxt  = dpdc_pkg::DST_WAKE;
          tmr_nxt = WAKE_CYC;
        end
      end
      dpdc_pkg::DST_WAKE: begin
        if (tmr_r == 11'h000) begin
          st_nxt = dpdc_pkg::DST_STANDBY;
        end
      end
      default: begin
        st_nxt = dpdc_pkg::DST_STANDBY;
      end
    endcase
  end

  // Line mode is synchronised on the free-running clock: the link clock stops
  // between frames, and mode only changes with enable high, so it is settled
  // well before the first link edge of a frame
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      quad_s1_r   <= 1'b0;
      quad_s2_r   <= 1'b0;
      ce_s1_r     <= 1'b1;
      ce_s2_r     <= 1'b1;
      ce_s3_r     <= 1'b1;
      tg_s1_r     <= 1'b0;
      tg_s2_r     <= 1'b0;
      tg_s3_r     <= 1'b0;
      op_lat_r    <= 8'h00;
      have_r      <= 1'b0;
      st_r        <= dpdc_pkg::DST_STANDBY;
      tmr_r       <= 11'h000;
      o_cmd_valid <= 1'b0;
      o_cmd_code  <= 8'h00;
      o_low_power <= 1'b0;
      o_ready     <= 1'b1;
    end else begin
      quad_s1_r   <= i_quad_mode;
      quad_s2_r   <= quad_s1_r;
      ce_s1_r     <= link.ce_n;
      ce_s2_r     <= ce_s1_r;
      ce_s3_r     <= ce_s2_r;
      tg_s1_r     <= tog_r;
      tg_s2_r     <= tg_s1_r;
      tg_s3_r     <= tg_s2_r;
      op_lat_r    <= op_lat_nxt;
      have_r      <= have_nxt;
      st_r        <= st_nxt;
      tmr_r       <= tmr_nxt;
      o_cmd_valid <= vld_nxt;
      o_cmd_code  <= code_nxt;
      o_low_power <= (st_nxt == dpdc_pkg::DST_LOWPWR);
      o_ready     <= (st_nxt == dpdc_pkg::DST_STANDBY);
    end
  end
endmodule : dpdc_device

// ==== design/dpdc_host.sv ====
// Host-side controller: sends one opcode frame, optionally reads the ID
`timescale 1ns/1ps
`include "dpdc_defs.svh"
module dpdc_host (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_quad_mode,
  input  wire logic                   i_req,
  input  wire logic [`DPDC_OP_W-1:0]  i_opcode,
  input  wire logic                   i_read_id,
  output logic                        o_busy,
  output logic                        o_done,
  output logic [`DPDC_ID_W-1:0]       o_id,
  dpdc_link_if.host                   link
);
  localparam logic [`DPDC_CNT_W-1:0] WAKE_CYC = `DPDC_CNT_W'(`DPDC_WAKE_CYC);

  // Clock 8x slower than reference; gives the read sampler time to settle
  logic [2:0]                 ph_r;
  dpdc_pkg::dpdc_host_state_t st_r;
  dpdc_pkg::dpdc_host_state_t st_nxt;
  logic [`DPDC_CNT_W-1:0]     cnt_r;
  logic [`DPDC_CNT_W-1:0]     cnt_nxt;
  logic [`DPDC_OP_W-1:0]      sh_r;
  logic [`DPDC_OP_W-1:0]      sh_nxt;
  logic                       quad_r;
  logic                       quad_nxt;
  logic                       rid_r;
  logic                       rid_nxt;
  logic                       rel_seen_r;
  logic                       rel_seen_nxt;
  logic [`DPDC_ID_W-1:0]      id_nxt;
  logic                       ce_n_r;
  logic                       ce_n_nxt;
  logic                       sck_r;
  logic                       sck_nxt;
  logic [3:0]                 dq_o_r;
  logic [3:0]                 dq_o_nxt;
  logic [3:0]                 dq_oe_r;
  logic [3:0]                 dq_oe_nxt;
  logic                       done_nxt;
  logic [3:0]                 dq_s1_r;
  logic [3:0]                 dq_s2_r;
  logic                       last;
  logic [`DPDC_CNT_W-1:0]     op_clk;
  logic [`DPDC_CNT_W-1:0]     id_clk;

  assign last   = (ph_r == 3'h7);
  assign op_clk = quad_r ? `DPDC_CNT_W'(`DPDC_CLK_QUAD) : `DPDC_CNT_W'(`DPDC_CLK_SINGLE);
  assign id_clk = quad_r ? `DPDC_CNT_W'(`DPDC_ID_W / 4) : `DPDC_CNT_W'(`DPDC_ID_W);

  // Frame sequencer; link steps align to the end of a clock period, read samples at phase 3, gap and wake counts run every reference cycle
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    quad_nxt  = quad_r;
    rid_nxt   = rid_r;
    rel_seen_nxt = rel_seen_r;
    id_nxt    = o_id;
    ce_n_nxt  = ce_n_r;
    dq_o_nxt  = dq_o_r;
    dq_oe_nxt = dq_oe_r;
    done_nxt  = 1'b0;
    unique case (st_r)
      dpdc_pkg::HST_IDLE: begin
        if (i_req) begin
          st_nxt   = dpdc_pkg::HST_SETUP;
          sh_nxt   = i_opcode;
          quad_nxt = i_quad_mode;
          rid_nxt  = i_read_id & (i_opcode == `DPDC_OP_RELEASE);
          rel_seen_nxt = (i_opcode == `DPDC_OP_RELEASE);
          ce_n_nxt = 1'b0;
        end
      end
      dpdc_pkg::HST_SETUP: begin
        if (last) begin
          st_nxt    = dpdc_pkg::HST_OP;
          cnt_nxt   = 11'h000;
          dq_oe_nxt = quad_r ? 4'hF : 4'h1;
          dq_o_nxt  = quad_r ? sh_r[7:4] : {3'b000, sh_r[7]};
          sh_nxt    = quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
        end
      end
      dpdc_pkg::HST_OP: begin
        if (last) begin
          cnt_nxt = cnt_r + 11'h001;
          if (cnt_nxt == op_clk) begin
            cnt_nxt   = 11'h000;
            dq_oe_nxt = 4'h0;
            st_nxt    = rid_r ? dpdc_pkg::HST_DUMMY : dpdc_pkg::HST_END;
          end else begin
            dq_o_nxt = quad_r ? sh_r[7:4] : {3'b000, sh_r[7]};
            sh_nxt   = quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
          end
        end
      end
      dpdc_pkg::HST_DUMMY: begin
        if (last) begin
          cnt_nxt = cnt_r + 11'h001;
          if (cnt_nxt == 11'(`DPDC_DUMMY_CLK)) begin
            cnt_nxt = 11'h000;
            st_nxt  = dpdc_pkg::HST_READ;
          end
        end
      end
      dpdc_pkg::HST_READ: begin
        // Sample late in the low phase, after the two-flop settle
        if (ph_r == 3'h3) begin
          id_nxt = quad_r ? {o_id[`DPDC_ID_W-5:0], dq_s2_r}
                          : {o_id[`DPDC_ID_W-2:0], dq_s2_r[1]};
        end
        if (last) begin
          cnt_nxt = cnt_r + 11'h001;
          st_nxt  = (cnt_nxt == id_clk) ? dpdc_pkg::HST_END : st_r;
        end
      end
      dpdc_pkg::HST_END: begin
        if (last) begin
          ce_n_nxt = 1'b1;
          cnt_nxt  = 11'(`DPDC_GAP_CYC);
          st_nxt   = dpdc_pkg::HST_GAP;
        end
      end
      dpdc_pkg::HST_GAP: begin
        cnt_nxt = cnt_r - 11'h001;
        if (cnt_r == 11'h000) begin
          cnt_nxt = 11'h000;                                       // No wait unless release
          st_nxt  = dpdc_pkg::HST_WAKE;
        end
      end
      dpdc_pkg::HST_WAKE: begin
        // After a release frame, no new frame until the device is back in standby
        cnt_nxt = (cnt_r == 11'h000) ? cnt_r : cnt_r - 11'h001;
        if (cnt_r == 11'h000) begin
          st_nxt   = dpdc_pkg::HST_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = dpdc_pkg::HST_IDLE;
      end
    endcase
    // Any release frame waits out the wake time, read or not
    if (st_r == dpdc_pkg::HST_GAP && cnt_r == 11'h000 && rel_seen_r) begin
      cnt_nxt = WAKE_CYC;
    end
    sck_nxt = (st_nxt == dpdc_pkg::HST_OP || st_nxt == dpdc_pkg::HST_DUMMY ||
               st_nxt == dpdc_pkg::HST_READ) & ((ph_r + 3'h1) >= 3'h4);
  end

  // Registers of the frame sequencer; rel_seen_r remembers a release frame
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_r       <= 3'h0;
      st_r       <= dpdc_pkg::HST_IDLE;
      cnt_r      <= 11'h000;
      sh_r       <= 8'h00;
      quad_r     <= 1'b0;
      rid_r      <= 1'b0;
      rel_seen_r <= 1'b0;
      o_id       <= 24'h000000;
      ce_n_r     <= 1'b1;
      sck_r      <= 1'b0;
      dq_o_r     <= 4'h0;
      dq_oe_r    <= 4'h0;
      dq_s1_r    <= 4'h0;
      dq_s2_r    <= 4'h0;
      o_done     <= 1'b0;
      o_busy     <= 1'b0;
    end else begin
      ph_r       <= ph_r + 3'h1;
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      quad_r     <= quad_nxt;
      rid_r      <= rid_nxt;
      rel_seen_r <= rel_seen_nxt;
      o_id       <= id_nxt;
      ce_n_r     <= ce_n_nxt;
      sck_r      <= sck_nxt;
      dq_o_r     <= dq_o_nxt;
      dq_oe_r    <= dq_oe_nxt;
      dq_s1_r    <= link.dq;
      dq_s2_r    <= dq_s1_r;
      o_done     <= done_nxt;
      o_busy     <= (st_nxt != dpdc_pkg::HST_IDLE);
    end
  end

  assign link.sck        = sck_r;
  assign link.ce_n       = ce_n_r;
  assign link.host_dq_o  = dq_o_r;
  assign link.host_dq_oe = dq_oe_r;
endmodule : dpdc_host

// ==== testbench/dpdc_link_chk.sv ====
// Concurrent checks on the power-state control link wires
`timescale 1ns/1ps
module dpdc_link_chk (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       sck,
  input wire logic       ce_n,
  input wire logic [3:0] host_dq_o,
  input wire logic [3:0] host_dq_oe,
  input wire logic [3:0] dev_dq_o,
  input wire logic [3:0] dev_dq_oe,
  input wire logic [3:0] dq
);
  logic       sck_r;
  logic       sck_nxt;
  logic [5:0] rise_r;
  logic [5:0] rise_nxt;
  logic [5:0] op_r;
  logic [5:0] op_nxt;

  // Edge counts per frame; cleared while enable is high so a frame starts at zero
  always_comb begin
    sck_nxt  = sck;
    rise_nxt = rise_r;
    op_nxt   = op_r;
    if (ce_n) begin
      rise_nxt = 6'h00;
      op_nxt   = 6'h00;
    end else if (sck && !sck_r) begin
      rise_nxt = rise_r + 6'h01;
      op_nxt   = (|host_dq_oe) ? op_r + 6'h01 : op_r;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_r  <= 1'b0;
      rise_r <= 6'h00;
      op_r   <= 6'h00;
    end else begin
      sck_r  <= sck_nxt;
      rise_r <= rise_nxt;
      op_r   <= op_nxt;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_ce_up;
    $rose(ce_n);
  endsequence
  sequence s_dev_start;
    $rose(|dev_dq_oe);
  endsequence

  property p_frame_ends;
    $fell(ce_n) |-> ##[1:1000] s_ce_up;
  endproperty
  property p_sck_still;
    ce_n |-> !sck;
  endproperty
  property p_dev_off;
    ce_n |-> dev_dq_oe == 4'h0;
  endproperty
  property p_no_fight;
    (host_dq_oe & dev_dq_oe) == 4'h0;
  endproperty
  property p_host_lanes;
    host_dq_oe inside {4'h0, 4'h1, 4'hF};
  endproperty
  property p_dev_lanes;
    dev_dq_oe inside {4'h0, 4'h2, 4'hF};
  endproperty
  // Host must hand over the lines after exactly one opcode worth of clocks
  property p_op_clocks;
    $fell(|host_dq_oe) && !$past(ce_n) |-> op_r == 6'h08 || op_r == 6'h02;
  endproperty
  property p_dummy_first;
    s_dev_start |-> rise_r == 6'h0B || rise_r == 6'h05;
  endproperty
  property p_id_on_fall;
    !ce_n && (|dev_dq_oe) && $changed(dev_dq_o) |-> !sck;
  endproperty
  property p_host_hold;
    (|host_dq_oe) && sck && $past(sck) |-> $stable(host_dq_o);
  endproperty
  // Device bits must reach the lines it enables
  property p_dev_reach;
    ((dq ^ dev_dq_o) & dev_dq_oe) == 4'h0;
  endproperty

  a_frame_ends: assert property (p_frame_ends) else $error("frame never closed");
  a_sck_still: assert property (p_sck_still) else $error("clock moved outside frame");
  a_dev_off: assert property (p_dev_off) else $error("device drives with enable high");
  a_no_fight: assert property (p_no_fight) else $error("both ends drive a line");
  a_host_lanes: assert property (p_host_lanes) else $error("bad host lanes");
  a_dev_lanes: assert property (p_dev_lanes) else $error("bad device lanes");
  a_op_clocks: assert property (p_op_clocks) else $error("wrong opcode clocks");
  a_dummy_first: assert property (p_dummy_first) else $error("id before dummies");
  a_id_on_fall: assert property (p_id_on_fall) else $error("id moved off falling edge");
  a_host_hold: assert property (p_host_hold) else $error("host data moved");
  a_dev_reach: assert property (p_dev_reach) else $error("id bit lost on line");
endmodule : dpdc_link_chk

// ==== testbench/deep_power_down_control_bench.sv ====
// Self-checking bench joining host and device across one link
`timescale 1ns/1ps
`include "dpdc_defs.svh"
module deep_power_down_control_bench;
  localparam logic [23:0] ID_VAL = 24'h5AC317; // Arbitrary identifier value
  logic        i_ref_clk;
  logic        i_rst_n;
  logic        quad, req, rd, wr_busy;
  logic        host_busy, host_done, lp, rdy, cmd_valid;
  logic [7:0]  op, cmd_code;
  logic [23:0] host_id;
  int          fail_count;
  int          cmp_count;

  dpdc_link_if link_if ();

  dpdc_host dpdc_host_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_quad_mode(quad),
    .i_req(req), .i_opcode(op), .i_read_id(rd), .o_busy(host_busy), .o_done(host_done),
    .o_id(host_id), .link(link_if));
  dpdc_device dpdc_device_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_quad_mode(quad),
    .i_wr_busy(wr_busy), .link(link_if), .o_low_power(lp), .o_ready(rdy),
    .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code));
  dpdc_link_chk dpdc_link_chk_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .sck(link_if.sck), .ce_n(link_if.ce_n), .host_dq_o(link_if.host_dq_o),
    .host_dq_oe(link_if.host_dq_oe), .dev_dq_o(link_if.dev_dq_o),
    .dev_dq_oe(link_if.dev_dq_oe), .dq(link_if.dq));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One frame; tracks device state from enable rise until settled and the host is done
  task automatic xfer(input logic [7:0] c, input logic r, input logic q, input logic e_lp,
                      input logic e_rdy, input int lim, output int pulses);
    int n, since, lat;
    logic lp0, rdy0, ce_q, got_done;
    lat = -1;
    pulses = 0;
    since = -1;
    lp0 = lp;
    rdy0 = rdy;
    ce_q = 1'b1;
    got_done = 1'b0;
    @(posedge i_ref_clk);
    quad <= q;
    op <= c;
    rd <= r;
    req <= 1'b1;
    for (n = 0; n < 4000; n++) begin
      @(posedge i_ref_clk);
      if (host_busy === 1'b1) req <= 1'b0;
      if (cmd_valid === 1'b1) pulses++;
      if (host_done === 1'b1) got_done = 1'b1;
      if (since < 0 && ce_q === 1'b0 && link_if.ce_n === 1'b1) since = 0;
      ce_q = link_if.ce_n;
      if (since < 0) begin
        chk({22'h0, lp, rdy}, {22'h0, lp0, rdy0});
      end else begin
        if (lat < 0) begin
          if (lp === e_lp && rdy === e_rdy) lat = since;
        end else chk({22'h0, lp, rdy}, {22'h0, e_lp, e_rdy});
        since++;
        if (got_done && since > 400 && (lat >= 0 || since > 1100)) break;
      end
    end
    cmp_count++;
    if (n == 4000 || lat < 0 || lat > lim) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, lat, lim);
      if (n == 4000) give_verdict();
    end
  endtask : xfer

  task automatic sc_forward(input logic [7:0] c, input logic q);
    int p;
    xfer(c, 1'b0, q, 1'b0, 1'b1, 1000, p);
    chk(24'(p), 24'h000001);
    chk({16'h0, cmd_code}, {16'h0, c});
  endtask : sc_forward

  task automatic sc_enter(input logic q);
    int p;
    xfer(`DPDC_OP_ENTER, 1'b0, q, 1'b1, 1'b0, 300, p);
    chk(24'(p), 24'h000000);
  endtask : sc_enter

  // Plain opcode while powered down must vanish without a forward pulse
  task automatic sc_ignore();
    int p;
    xfer(8'h06, 1'b0, 1'b0, 1'b1, 1'b0, 1000, p);
    chk(24'(p), 24'h000000);
  endtask : sc_ignore

  task automatic sc_release(input logic r, input logic q);
    int p;
    xfer(`DPDC_OP_RELEASE, r, q, 1'b0, 1'b1, 1000, p);
    chk(24'(p), 24'h000000);
    if (r) chk(host_id, ID_VAL);
  endtask : sc_release

  // Enter request during a program or erase leaves standby untouched
  task automatic sc_busy();
    int p;
    @(posedge i_ref_clk);
    wr_busy <= 1'b1;
    xfer(`DPDC_OP_ENTER, 1'b0, 1'b0, 1'b0, 1'b1, 1000, p);
    chk(24'(p), 24'h000000);
    wr_busy <= 1'b0;
  endtask : sc_busy

  initial begin
    i_rst_n = 1'b0;
    quad = 1'b0;
    req = 1'b0;
    op = 8'h00;
    rd = 1'b0;
    wr_busy = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    sc_forward(8'hC5, 1'b0);
    sc_enter(1'b0);
    sc_ignore();
    sc_release(1'b1, 1'b0);
    sc_forward(8'h3A, 1'b1);
    sc_enter(1'b1);
    sc_release(1'b1, 1'b1);
    sc_busy();
    sc_enter(1'b0);
    sc_release(1'b0, 1'b0);
    give_verdict();
  end
endmodule : deep_power_down_control_bench
